// ===== bench/phyan_mgmt_model.sv
// Station management controller driving management frames
`timescale 1ns/1ps
`default_nettype none
`include "phyan_cfg.svh"
module phyan_mgmt_model (
	input wire logic sys_clk,
	input wire logic mdio_line,
	output logic mdc,
	output logic mdio_drv,
	output logic mdio_en
);
	// Clock stands low between frames
	initial begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
		mdio_en = 1'b0;
	end

	// One bit: 4 cycles low, sample, 4 cycles high
	task automatic bit_cyc(input logic en, input logic d, output logic seen);
		mdio_en = en;
		mdio_drv = d;
		repeat (4) @(posedge sys_clk);
		#1;
		seen = mdio_line;
		mdc = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		mdc = 1'b0;
	endtask

	task automatic xfer(input logic [1:0] op, input logic [4:0] phyad, input logic [4:0] regad,
		input logic [15:0] wdata, output logic [15:0] rdata, output logic ta_seen);
		logic [13:0] head;
		logic s;
		head = {2'h1, op, phyad, regad};
		rdata = 16'h0000;
		ta_seen = 1'b1;
		@(posedge sys_clk);
		#1;
		for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_cyc(1'b1, head[i], s);
		if (op == `PHYAN_OP_WRITE) begin
			bit_cyc(1'b1, 1'b1, s);
			bit_cyc(1'b1, 1'b0, s);
			for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wdata[i], s);
		end else begin
			bit_cyc(1'b0, 1'b1, s);
			bit_cyc(1'b0, 1'b1, ta_seen);
			for (int i = 15; i >= 0; i--) bit_cyc(1'b0, 1'b1, rdata[i]);
		end
		mdio_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== bench/phyan_regs_bench.sv
// Self-checking bench of the identifier and advertisement registers
`timescale 1ns/1ps
`default_nettype none
`include "phyan_cfg.svh"
module phyan_regs_bench;
	import phyan_pkg::*;
	// ----------------------------------------
	// Set-up
	// ----------------------------------------
	localparam logic [4:0] PHY = 5'h0B;
	localparam logic [4:0] PHY_BLANK = 5'h0C;
	localparam logic [1:24] ORG = 24'hC3A5E1; // Arbitrary value
	localparam logic [5:0] MODEL = 6'h2B; // Arbitrary value
	localparam logic [3:0] REV = 4'h9; // Arbitrary value
	localparam phyan_word_type ID_HI = ORG[3:18];
	localparam phyan_word_type ID_LO = {ORG[19:24], MODEL, REV};
	typedef struct packed {logic wr; phyan_regad_type regad; phyan_word_type data;} phyan_row_type;
	logic sys_clk;
	logic resetn;
	logic mdc;
	logic mdio_out;
	logic mdio_oe_n;
	logic mdio_drv;
	logic mdio_en;
	logic mdio_line;
	logic blank_out;
	logic blank_oe_n;
	logic [3:0] ability_strap;
	logic an_start;
	phyan_word_type adv_to_an;
	int error_cnt = 0;
	int compares = 0;
	phyan_row_type rows[12] = '{
		'{1'b0, `PHYAN_REG_ID_HIGH, ID_HI},
		'{1'b0, `PHYAN_REG_ID_LOW, ID_LO},
		'{1'b0, `PHYAN_REG_ADVERT, 16'h0141},
		'{1'b1, `PHYAN_REG_ADVERT, 16'hEFFF},
		'{1'b0, `PHYAN_REG_ADVERT, 16'hADFF},
		'{1'b1, `PHYAN_REG_ID_HIGH, 16'h0000},
		'{1'b1, `PHYAN_REG_ID_LOW, ~ID_LO},
		'{1'b0, `PHYAN_REG_ID_HIGH, ID_HI},
		'{1'b0, `PHYAN_REG_ID_LOW, ID_LO},
		'{1'b0, 5'h05, 16'h0000},
		'{1'b1, `PHYAN_REG_ADVERT, 16'h0000},
		'{1'b0, `PHYAN_REG_ADVERT, 16'h0000}
	};

	// Pull-up on the shared data line
	assign mdio_line = !mdio_oe_n ? mdio_out : (!blank_oe_n ? blank_out : (mdio_en ? mdio_drv : 1'b1));

	phyan_regs #(.PHY_ADDR(PHY), .ORG_ID(ORG), .MODEL_NUM(MODEL), .MODEL_REV(REV), .ID_BLANK(1'b0)) i_phyan_regs (
		.sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .ability_strap(ability_strap), .an_start(an_start), .adv_to_an(adv_to_an));
	// Second device on the same pins, built with a blank identity
	phyan_regs #(.PHY_ADDR(PHY_BLANK), .ORG_ID(ORG), .MODEL_NUM(MODEL), .MODEL_REV(REV), .ID_BLANK(1'b1))
		i_phyan_regs_blank (
		.sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(blank_out),
		.mdio_oe_n(blank_oe_n), .ability_strap(ability_strap), .an_start(an_start), .adv_to_an());
	phyan_mgmt_model i_phyan_mgmt_model (.sys_clk(sys_clk), .mdio_line(mdio_line), .mdc(mdc),
		.mdio_drv(mdio_drv), .mdio_en(mdio_en));

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input phyan_word_type seen, input phyan_word_type exp, input string msg);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("Compares %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic mgmt(input logic [1:0] op, input logic [4:0] phyad, input phyan_regad_type regad,
		input phyan_word_type wdata, output phyan_word_type rdata);
		logic ta;
		i_phyan_mgmt_model.xfer(op, phyad, regad, wdata, rdata, ta);
		if (op == `PHYAN_OP_READ) check({15'h0000, ta}, 16'h0000, "turnaround");
		repeat (4) @(posedge sys_clk);
		#1;
		check({15'h0000, mdio_oe_n}, 16'h0001, "pin released");
		check({15'h0000, blank_oe_n}, 16'h0001, "blank pin released");
	endtask

	task automatic pulse_start;
		@(posedge sys_clk);
		#1;
		an_start = 1'b1;
		@(posedge sys_clk);
		#1;
		an_start = 1'b0;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		phyan_word_type rd;
		resetn = 1'b0;
		an_start = 1'b0;
		ability_strap = 4'hA;
		repeat (6) @(posedge sys_clk);
		#1;
		check(adv_to_an, 16'h0000, "snapshot in reset");
		check({15'h0000, mdio_oe_n}, 16'h0001, "pin idle in reset");
		resetn = 1'b1;
		foreach (rows[i]) begin
			mgmt(rows[i].wr ? `PHYAN_OP_WRITE : `PHYAN_OP_READ, PHY, rows[i].regad, rows[i].data, rd);
			if (!rows[i].wr) check(rd, rows[i].data, "register read");
		end
		// Snapshot taken only at negotiation start
		mgmt(`PHYAN_OP_WRITE, PHY, `PHYAN_REG_ADVERT, 16'h8C61, rd);
		pulse_start();
		check(adv_to_an, 16'h8C61, "advert handed over");
		mgmt(`PHYAN_OP_WRITE, PHY, `PHYAN_REG_ADVERT, 16'h2481, rd);
		check(adv_to_an, 16'h8C61, "snapshot held");
		pulse_start();
		check(adv_to_an, 16'h2481, "next exchange");
		// Foreign address and illegal opcodes are ignored
		mgmt(`PHYAN_OP_WRITE, PHY ^ 5'h01, `PHYAN_REG_ADVERT, 16'h0000, rd);
		mgmt(2'h0, PHY, `PHYAN_REG_ADVERT, 16'h0000, rd);
		mgmt(2'h3, PHY, `PHYAN_REG_ADVERT, 16'h0000, rd);
		mgmt(`PHYAN_OP_READ, PHY, `PHYAN_REG_ADVERT, 16'h0000, rd);
		check(rd, 16'h2481, "refused frames");
		// Blank identity build returns zeros
		mgmt(`PHYAN_OP_READ, PHY_BLANK, `PHYAN_REG_ID_HIGH, 16'h0000, rd);
		check(rd, 16'h0000, "blank identity high");
		mgmt(`PHYAN_OP_READ, PHY_BLANK, `PHYAN_REG_ID_LOW, 16'h0000, rd);
		check(rd, 16'h0000, "blank identity low");
		// Second reset picks up new straps
		@(posedge sys_clk);
		#1;
		resetn = 1'b0;
		ability_strap = 4'h5;
		repeat (6) @(posedge sys_clk);
		#1;
		check(adv_to_an, 16'h0000, "snapshot cleared");
		resetn = 1'b1;
		mgmt(`PHYAN_OP_READ, PHY, `PHYAN_REG_ADVERT, 16'h0000, rd);
		check(rd, 16'h00A1, "strap reset value");
		summarize();
	end

	initial begin
		#2_000_000;
		error_cnt++;
		$display("wrong value at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire

// ===== rtl/phyan_cfg.svh
// Register offsets, field positions and frame constants of the identifier/advertisement bank
`ifndef PHYAN_CFG_SVH
`define PHYAN_CFG_SVH

// Register addresses
`define PHYAN_REG_ID_HIGH 5'h02
`define PHYAN_REG_ID_LOW 5'h03
`define PHYAN_REG_ADVERT 5'h04

// Advertisement field positions
`define PHYAN_NP_BIT 15
`define PHYAN_RSV14_BIT 14
`define PHYAN_RF_BIT 13
`define PHYAN_RSV12_BIT 12
`define PHYAN_ASYM_BIT 11
`define PHYAN_PAUSE_BIT 10
`define PHYAN_T4_BIT 9
`define PHYAN_ABIL_HI 8
`define PHYAN_ABIL_LO 5
`define PHYAN_SEL_HI 4
`define PHYAN_SEL_LO 0

// Reset values
`define PHYAN_FLAG_RESET 1'h0
`define PHYAN_SEL_RESET 5'h01
`define PHYAN_WORD_ZERO 16'h0000

// Management frame constants
`define PHYAN_PRE_LEN 6'h20
`define PHYAN_HEAD_LAST 4'hC
`define PHYAN_TA_LAST 4'h1
`define PHYAN_DATA_LAST 4'hF
`define PHYAN_OP_READ 2'h2
`define PHYAN_OP_WRITE 2'h1

`endif

// ===== rtl/phyan_field_reg.sv
// One writable advertisement field with a supplied reset value
`timescale 1ns/1ps
`default_nettype none
module phyan_field_reg #(
	parameter int WIDTH = 1,
	parameter int LSB = 0
) (
	input wire logic sys_clk,
	input wire logic resetn,
	phyan_wr_if.field bus,
	input wire logic [WIDTH-1:0] reset_value,
	output logic [WIDTH-1:0] value
);
	if (WIDTH < 1 || LSB < 0 || LSB + WIDTH > 16) begin : g_chk
		$error("phyan_field_reg: field must lie within 16 bits");
	end

	// Reset value may be a strap level, caught while reset is low
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			value <= reset_value;
		end else if (bus.adv_wr) begin
			value <= bus.wr_data[LSB +: WIDTH];
		end
	end
endmodule
`default_nettype wire

// ===== rtl/phyan_pkg.sv
// Types shared by the identifier/advertisement bank
package phyan_pkg;
	typedef logic [15:0] phyan_word_type;
	typedef logic [4:0] phyan_regad_type;
	typedef enum logic [2:0] {
		st_idle,
		st_head,
		st_rd_ta,
		st_rd_data,
		st_rd_end,
		st_wr_ta,
		st_wr_data
	} phyan_frame_type;
endpackage

// ===== rtl/phyan_regs.sv
// Identifier and advertisement registers behind the serial management pins
//
// Overview of operation
// RULE1: 32-bit identity is organisation id, model number and revision over two registers.
// RULE2: A build option returns all 32 identity bits as zero.
// RULE3: First identity register holds organisation id bits 3..18 in bits 15..0, read-only.
// RULE4: Organisation id bits 1 and 2 are stored nowhere.
// RULE5: Second identity register bits 15..10 hold organisation id bits 19..24.
// RULE6: Second identity register bits 9..4 hold six-bit model number, MSB at 9.
// RULE7: Second identity register bits 3..0 hold four-bit revision, MSB at 3.
// RULE8: Advertised abilities are handed to the negotiation engine when it runs.
// RULE9: Bit 15 next-page request, read-write, resets to 0.
// RULE10: Bit 14 reserved, writes ignored, reads 0.
// RULE11: Bit 13 remote fault advert, read-write, resets to 0.
// RULE12: Bit 12 reserved, resets 0, reads 0; controller should write 0.
// RULE13: Bit 11 asymmetric pause advert, read-write, resets to 0.
// RULE14: Bit 10 symmetric pause advert, read-write, resets to 0.
// RULE15: Bit 9 four-pair 100M ability reads 0 always.
// RULE16: Bits 8..5 speed/duplex abilities, read-write, reset from strap pins.
// RULE17: Bits 4..0 protocol selector, read-write, resets to 00001.
// RULE18: Read-only fields are readable over management; writes to them do nothing.
// RULE19: Advert changes reach the partner only at the next negotiation start.
`include "phyan_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module phyan_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter logic [1:24] ORG_ID = 24'h5A3C96, // Arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h15, // Arbitrary value
	parameter logic [3:0] MODEL_REV = 4'h2, // Arbitrary value
	parameter bit ID_BLANK = 1'b0
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic [3:0] ability_strap,
	input wire logic an_start,
	output phyan_pkg::phyan_word_type adv_to_an
);
	import phyan_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic mdc_s;
	logic mdio_s;
	logic [3:0] strap_s;
	logic mdc_prev;
	logic rise;

	phyan_sync #(.WIDTH(6)) u_sync (
		.sys_clk(sys_clk),
		.async_in({mdc, mdio_in, ability_strap}),
		.sync_out({mdc_s, mdio_s, strap_s})
	);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mdc_prev <= 1'b0;
		end else begin
			mdc_prev <= mdc_s;
		end
	end

	assign rise = mdc_s & ~mdc_prev;

	// ------------------------------------------------------------
	// Identity words
	// ------------------------------------------------------------
	localparam phyan_word_type ID_HIGH_VAL = ID_BLANK ? `PHYAN_WORD_ZERO : ORG_ID[3:18]; // RULE2 RULE3 RULE4
	localparam phyan_word_type ID_LOW_VAL = ID_BLANK ? `PHYAN_WORD_ZERO :
		{ORG_ID[19:24], MODEL_NUM, MODEL_REV}; // RULE1 RULE5 RULE6 RULE7

	// ------------------------------------------------------------
	// Advertisement fields
	// ------------------------------------------------------------
	phyan_wr_if wr_bus ();
	logic next_page_request;
	logic remote_fault_advert;
	logic asymmetric_pause_advert;
	logic pause_advert;
	logic [3:0] ability;
	logic [4:0] selector;
	phyan_word_type adv_word;

	phyan_field_reg #(.WIDTH(1), .LSB(`PHYAN_NP_BIT)) u_np ( // RULE9
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(`PHYAN_FLAG_RESET), .value(next_page_request)
	);
	phyan_field_reg #(.WIDTH(1), .LSB(`PHYAN_RF_BIT)) u_rf ( // RULE11
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(`PHYAN_FLAG_RESET), .value(remote_fault_advert)
	);
	phyan_field_reg #(.WIDTH(1), .LSB(`PHYAN_ASYM_BIT)) u_asym ( // RULE13
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(`PHYAN_FLAG_RESET), .value(asymmetric_pause_advert)
	);
	phyan_field_reg #(.WIDTH(1), .LSB(`PHYAN_PAUSE_BIT)) u_pause ( // RULE14
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(`PHYAN_FLAG_RESET), .value(pause_advert)
	);
	phyan_field_reg #(.WIDTH(4), .LSB(`PHYAN_ABIL_LO)) u_abil ( // RULE16
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(strap_s), .value(ability)
	);
	phyan_field_reg #(.WIDTH(5), .LSB(`PHYAN_SEL_LO)) u_sel ( // RULE17
		.sys_clk(sys_clk), .resetn(resetn), .bus(wr_bus.field),
		.reset_value(`PHYAN_SEL_RESET), .value(selector)
	);

	// Reserved bits and four-pair ability read as zero
	assign adv_word = {next_page_request, 1'b0, remote_fault_advert, 1'b0,
		asymmetric_pause_advert, pause_advert, 1'b0, ability, selector}; // RULE10 RULE12 RULE15

	// ------------------------------------------------------------
	// Management frame decoder
	// ------------------------------------------------------------
	phyan_frame_type state;
	logic [5:0] ones;
	logic [3:0] cnt;
	logic [11:0] head;
	logic [12:0] head_next;
	phyan_regad_type reg_sel;
	logic [14:0] wr_shift;
	logic head_done;
	logic addr_ok;
	logic rd_hit;
	logic wr_hit;

	assign head_next = {head, mdio_s};
	assign head_done = rise && state == st_head && cnt == `PHYAN_HEAD_LAST;
	assign addr_ok = head_next[12] && head_next[9:5] == PHY_ADDR;
	assign rd_hit = head_done && addr_ok && head_next[11:10] == `PHYAN_OP_READ;
	assign wr_hit = head_done && addr_ok && head_next[11:10] == `PHYAN_OP_WRITE;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= st_idle;
			ones <= 6'h00;
			cnt <= 4'h0;
			head <= 12'h000;
			reg_sel <= 5'h00;
			wr_shift <= 15'h0000;
		end else if (rise) begin
			unique case (state)
				st_idle: begin
					if (mdio_s) begin
						if (ones != `PHYAN_PRE_LEN) begin
							ones <= ones + 6'h01;
						end
					end else begin
						if (ones == `PHYAN_PRE_LEN) begin
							state <= st_head;
							cnt <= 4'h0;
						end
						ones <= 6'h00;
					end
				end
				st_head: begin
					head <= head_next[11:0];
					cnt <= cnt + 4'h1;
					if (cnt == `PHYAN_HEAD_LAST) begin
						cnt <= 4'h0;
						reg_sel <= head_next[4:0];
						if (rd_hit) begin
							state <= st_rd_ta;
						end else if (wr_hit) begin
							state <= st_wr_ta;
						end else begin
							state <= st_idle;
						end
					end
				end
				st_rd_ta: begin
					state <= st_rd_data;
					cnt <= 4'h0;
				end
				st_rd_data: begin
					cnt <= cnt + 4'h1;
					if (cnt == `PHYAN_DATA_LAST) begin
						state <= st_rd_end;
					end
				end
				st_rd_end: begin
					state <= st_idle;
				end
				st_wr_ta: begin
					cnt <= cnt + 4'h1;
					if (cnt == `PHYAN_TA_LAST) begin
						state <= st_wr_data;
						cnt <= 4'h0;
					end
				end
				st_wr_data: begin
					wr_shift <= {wr_shift[13:0], mdio_s};
					cnt <= cnt + 4'h1;
					if (cnt == `PHYAN_DATA_LAST) begin
						state <= st_idle;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register write strobe, advertisement only
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wr_bus.adv_wr <= 1'b0;
			wr_bus.wr_data <= `PHYAN_WORD_ZERO;
		end else begin
			wr_bus.adv_wr <= rise && state == st_wr_data && cnt == `PHYAN_DATA_LAST &&
				reg_sel == `PHYAN_REG_ADVERT; // RULE18
			wr_bus.wr_data <= {wr_shift, mdio_s};
		end
	end

	// ------------------------------------------------------------
	// Read data serialiser
	// ------------------------------------------------------------
	phyan_word_type rd_shift;
	phyan_word_type read_word;

	always_comb begin
		unique case (head_next[4:0])
			`PHYAN_REG_ID_HIGH: read_word = ID_HIGH_VAL; // RULE3
			`PHYAN_REG_ID_LOW: read_word = ID_LOW_VAL; // RULE5
			`PHYAN_REG_ADVERT: read_word = adv_word;
			default: read_word = `PHYAN_WORD_ZERO;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd_shift <= `PHYAN_WORD_ZERO;
			mdio_out <= 1'b0;
			mdio_oe_n <= 1'b1;
		end else if (rise) begin
			if (rd_hit) begin
				rd_shift <= read_word; // RULE18
			end else if (state == st_rd_ta) begin
				mdio_oe_n <= 1'b0;
				mdio_out <= 1'b0;
			end else if (state == st_rd_data) begin
				mdio_out <= rd_shift[15];
				rd_shift <= {rd_shift[14:0], 1'b0};
			end else if (state == st_rd_end) begin
				mdio_oe_n <= 1'b1;
				mdio_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Snapshot handed to the negotiation engine
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			adv_to_an <= `PHYAN_WORD_ZERO;
		end else if (an_start) begin
			adv_to_an <= adv_word; // RULE8 RULE19
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_rd_ta;
		rise && state == st_rd_ta;
	endsequence

	sequence s_drive_zero;
		!mdio_oe_n && !mdio_out;
	endsequence

	a_ta_drive_zero: assert property (s_rd_ta |=> s_drive_zero) // RULE18
		else $error("turnaround zero not driven");

	a_id_high_load: assert property (rd_hit && head_next[4:0] == `PHYAN_REG_ID_HIGH
		|=> rd_shift == ID_HIGH_VAL) // RULE3 RULE4
		else $error("identity high word wrong");

	a_id_low_load: assert property (rd_hit && head_next[4:0] == `PHYAN_REG_ID_LOW
		|=> rd_shift == ID_LOW_VAL) // RULE5 RULE6 RULE7 RULE1
		else $error("identity low word wrong");

	a_np_write: assert property (wr_bus.adv_wr
		|=> adv_word[`PHYAN_NP_BIT] == $past(wr_bus.wr_data[`PHYAN_NP_BIT])) // RULE9
		else $error("next page bit not written");

	a_reserved_zero: assert property (wr_bus.adv_wr |=> !adv_word[`PHYAN_RSV14_BIT]
		&& !adv_word[`PHYAN_RSV12_BIT] && !adv_word[`PHYAN_T4_BIT]) // RULE10 RULE12 RULE15
		else $error("reserved bit read back nonzero");

	a_strap_load: assert property ($rose(resetn)
		|-> adv_word[`PHYAN_ABIL_HI:`PHYAN_ABIL_LO] == $past(strap_s)) // RULE16
		else $error("ability bits not loaded from strap");

	a_sel_reset: assert property ($rose(resetn)
		|-> adv_word[`PHYAN_SEL_HI:`PHYAN_SEL_LO] == `PHYAN_SEL_RESET) // RULE17
		else $error("selector reset value wrong");

	a_ro_ignored: assert property (rise && state == st_wr_data && cnt == `PHYAN_DATA_LAST
		&& reg_sel != `PHYAN_REG_ADVERT |=> ##1 $stable(adv_word)) // RULE18
		else $error("write to read-only register changed advert");

	a_adv_snap: assert property (an_start |=> adv_to_an == $past(adv_word)) // RULE8
		else $error("advert not handed over at start");

	a_adv_hold: assert property (!an_start |=> $stable(adv_to_an)) // RULE19
		else $error("advert changed mid negotiation");
endmodule
`default_nettype wire

// ===== rtl/phyan_sync.sv
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module phyan_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1) begin : g_chk
		$error("phyan_sync: WIDTH must be at least 1");
	end

	// No reset, so strap pins still propagate while reset is held
	always_ff @(posedge sys_clk) begin
		stage1 <= async_in;
		sync_out <= stage1;
	end
endmodule
`default_nettype wire

// ===== rtl/phyan_wr_if.sv
// Write path from the frame engine to the advertisement fields
`timescale 1ns/1ps
`default_nettype none
interface phyan_wr_if;
	logic adv_wr;
	logic [15:0] wr_data;
	modport source (output adv_wr, output wr_data);
	modport field (input adv_wr, input wr_data);
endinterface
`default_nettype wire
